// file: hdl/mbs_handler.sv
// Slave frame interpreter for the serial register-access protocol
`timescale 1ns/100ps
`include "mbs_params.svh"
module mbs_handler
    import mbs_pkg::*;
#(
    parameter int GAP_CYCLES = int'(`MBS_GAP_CYCLES)
)(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  node_addr,
    input  wire logic        user_raw_mode,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             raw_rx_valid,
    output logic      [7:0]  raw_rx_data,
    input  wire logic        raw_tx_valid,
    input  wire logic [7:0]  raw_tx_data,
    output logic             raw_tx_ready,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [13:0] reg_addr,
    output logic             reg_wide,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata
);
    mbs_state_t  state;          // Sequencer state
    mbs_kind_t   kind;           // Reply shape
    logic [7:0]  req_buf [0:63]; // Received frame
    logic [7:0]  rd_buf  [0:39]; // Read reply data
    logic [6:0]  idx;            // Received byte count
    logic        gap;            // Idle gap pulse
    logic [15:0] crc_rx;         // Receive CRC residue
    logic [15:0] crc_tx;         // Transmit CRC
    logic [15:0] wr_start;       // Write start address
    logic [15:0] rd_start;       // Read start address
    logic [4:0]  wr_cnt;         // Registers to write
    logic [4:0]  rd_cnt;         // Registers to read
    logic [5:0]  dptr;           // First write data byte
    logic        wr_single;      // Single preset
    logic        rd_pend;        // Reads follow writes
    logic        bcast;          // Broadcast frame
    logic [4:0]  w;              // Write word index
    logic [4:0]  r;              // Read word index
    logic [15:0] hi_hold;        // Upper half of wide write
    logic [5:0]  tx_k;           // Reply byte index
    logic [5:0]  plen;           // Reply payload length
    logic        rx_take;        // Byte accepted into frame
    logic        tx_load;        // Byte loaded to transmitter
    logic        tx_free;        // Transmitter holding empty
    logic        next_tx_valid;  // Transmit valid next cycle
    logic [7:0]  tx_byte;        // Byte to load
    logic [5:0]  wp;             // Current write data byte
    logic [15:0] c1;             // Count field at byte 4
    logic [15:0] c2;             // Count field at byte 8
    logic        hit;            // Frame is for this node
    mbs_state_t  dec_next;       // Decoded next state
    mbs_kind_t   dec_kind;       // Decoded reply shape

    // Big-endian field of the received frame
    function automatic logic [15:0] f16(input logic [5:0] p);
        f16 = {req_buf[p], req_buf[p + 6'h01]};
    endfunction

    // Register count within limit
    function automatic logic cnt_ok(input logic [15:0] c);
        cnt_ok = (c != 16'h0000) && (c <= `MBS_MAX_REGS);
    endfunction

    // Reserved access-width codes
    function automatic logic rsv(input logic [15:0] a);
        rsv = a[15];
    endfunction

    assign rx_take = rx_valid && !user_raw_mode && state == ST_IDLE;
    assign c1 = f16(`MBS_POS_CNT);
    assign c2 = f16(`MBS_POS_WCNT);
    assign wp = dptr + {w, 1'b0};

    mbs_gap_timer #(.GAP_CYCLES(GAP_CYCLES)) u_gap (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .kick    (rx_take),
        .gap     (gap)
    );

    mbs_crc16 u_crc_rx (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (state == ST_CHECK),
        .en      (rx_take),
        .data    (rx_data),
        .crc     (crc_rx)
    );

    mbs_crc16 u_crc_tx (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (state != ST_TX),
        .en      (tx_load && !user_raw_mode && tx_k < plen),
        .data    (tx_byte),
        .crc     (crc_tx)
    );

    // Frame capture and raw pass-through
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idx          <= 7'h00;
            raw_rx_valid <= 1'b0;
            raw_rx_data  <= 8'h00;
        end else begin
            raw_rx_valid <= rx_valid && user_raw_mode;
            if (user_raw_mode) begin
                raw_rx_data <= rx_data;
            end
            if (state == ST_CHECK || user_raw_mode) begin
                idx <= 7'h00;
            end else if (rx_take && idx != 7'h40) begin
                idx <= idx + 7'h01;
            end
        end
    end

    // Frame store, kept out of the reset process on purpose
    always_ff @(posedge clk_sys) begin
        if (rx_take && idx != 7'h40) begin
            req_buf[idx[5:0]] <= rx_data;
        end
    end

    // Frame decode: address, CRC, code, layout, limits
    always_comb begin
        dec_next = ST_IDLE;
        dec_kind = RK_ECHO;
        hit = req_buf[0] == `MBS_BCAST ||
              (req_buf[0] == node_addr && node_addr != `MBS_BCAST &&
               node_addr <= `MBS_MAX_NODE);
        if (crc_rx == 16'h0000 && hit) begin
            case (req_buf[1])
                `MBS_FC_READ: begin
                    if (idx == `MBS_FIX_LEN && req_buf[0] != `MBS_BCAST) begin
                        dec_kind = RK_READ;
                        dec_next = ST_RD_REQ;
                        if (!cnt_ok(c1) || rsv(f16(`MBS_POS_ADDR))) begin
                            dec_kind = RK_EXC;
                            dec_next = ST_TX;
                        end
                    end
                end
                `MBS_FC_WRITE1: begin
                    if (idx == `MBS_FIX_LEN && !rsv(f16(`MBS_POS_ADDR))) begin
                        dec_next = ST_WR;
                    end
                end
                `MBS_FC_WRITEN: begin
                    if (cnt_ok(c1) && !rsv(f16(`MBS_POS_ADDR)) &&
                        idx == 7'(`MBS_HDR_N_LEN + {c1[14:0], 1'b0}) &&
                        req_buf[`MBS_POS_BC_N] == {c1[6:0], 1'b0}) begin
                        dec_next = ST_WR;
                    end
                end
                `MBS_FC_RDWR: begin
                    if (cnt_ok(c1) && cnt_ok(c2) &&
                        !rsv(f16(`MBS_POS_ADDR)) &&
                        !rsv(f16(`MBS_POS_WADDR)) &&
                        idx == 7'(`MBS_HDR_RW_LEN + {c2[14:0], 1'b0}) &&
                        req_buf[`MBS_POS_BC_RW] == {c2[6:0], 1'b0}) begin
                        dec_kind = RK_READ;
                        dec_next = ST_WR;
                    end
                end
                default: dec_next = ST_IDLE;
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            kind      <= RK_ECHO;
            wr_start  <= 16'h0000;
            rd_start  <= 16'h0000;
            wr_cnt    <= 5'h00;
            rd_cnt    <= 5'h00;
            dptr      <= 6'h00;
            wr_single <= 1'b0;
            rd_pend   <= 1'b0;
            bcast     <= 1'b0;
            w         <= 5'h00;
            r         <= 5'h00;
            tx_k      <= 6'h00;
        end else if (user_raw_mode) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (gap && idx != 7'h00) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state     <= dec_next;
                    kind      <= dec_kind;
                    bcast     <= req_buf[0] == `MBS_BCAST;
                    wr_single <= req_buf[1] == `MBS_FC_WRITE1;
                    rd_pend   <= req_buf[1] == `MBS_FC_RDWR;
                    w         <= 5'h00;
                    r         <= 5'h00;
                    tx_k      <= 6'h00;
                    rd_start  <= f16(`MBS_POS_ADDR);
                    rd_cnt    <= c1[4:0];
                    if (req_buf[1] == `MBS_FC_RDWR) begin
                        wr_start <= f16(`MBS_POS_WADDR);
                        wr_cnt   <= c2[4:0];
                        dptr     <= `MBS_POS_DATA_RW;
                    end else if (req_buf[1] == `MBS_FC_WRITE1) begin
                        wr_start <= f16(`MBS_POS_ADDR);
                        wr_cnt   <= 5'h01;
                        dptr     <= `MBS_POS_DATA_1;
                    end else begin
                        wr_start <= f16(`MBS_POS_ADDR);
                        wr_cnt   <= c1[4:0];
                        dptr     <= `MBS_POS_DATA_N;
                    end
                end
                ST_WR: begin
                    w <= w + 5'h01;
                    if (w == wr_cnt - 5'h01) begin
                        if (rd_pend && !bcast) begin
                            state <= ST_RD_REQ;
                        end else if (bcast) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_TX;
                        end
                    end
                end
                ST_RD_REQ: state <= ST_RD_CAP;
                ST_RD_CAP: begin
                    r     <= r + 5'h01;
                    state <= (r == rd_cnt - 5'h01) ? ST_TX : ST_RD_REQ;
                end
                ST_TX: begin
                    if (tx_load) begin
                        tx_k <= tx_k + 6'h01;
                    end
                    if (tx_k == plen + 6'h02 && tx_free) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Register store port: writes, then reads
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            reg_addr  <= 14'h0000;
            reg_wide  <= 1'b0;
            reg_wdata <= 32'h00000000;
            hi_hold   <= 16'h0000;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (state == ST_WR && !user_raw_mode) begin
                reg_wide <= wr_start[14];
                if (wr_single || !wr_start[14]) begin
                    reg_wr    <= 1'b1;
                    reg_addr  <= wr_start[13:0] + 14'(w);
                    reg_wdata <= {16'h0000, req_buf[wp],
                                  req_buf[wp + 6'h01]};
                end else if (w[0]) begin
                    reg_wr    <= 1'b1;
                    reg_addr  <= wr_start[13:0] + 14'(w >> 1);
                    reg_wdata <= {hi_hold, req_buf[wp], req_buf[wp + 6'h01]};
                end else begin
                    hi_hold <= {req_buf[wp], req_buf[wp + 6'h01]};
                end
            end else if (state == ST_RD_REQ && !user_raw_mode) begin
                reg_rd   <= 1'b1;
                reg_wide <= rd_start[14];
                reg_addr <= rd_start[13:0] +
                            14'(rd_start[14] ? (r >> 1) : r);
            end
        end
    end

    // Read data capture, high byte first
    always_ff @(posedge clk_sys) begin
        if (state == ST_RD_CAP) begin
            if (rd_start[14] && !r[0]) begin
                rd_buf[{r, 1'b0}]        <= reg_rdata[31:24];
                rd_buf[{r, 1'b0} + 6'h01] <= reg_rdata[23:16];
            end else begin
                rd_buf[{r, 1'b0}]        <= reg_rdata[15:8];
                rd_buf[{r, 1'b0} + 6'h01] <= reg_rdata[7:0];
            end
        end
    end

    // Reply byte selection
    always_comb begin
        plen = (kind == RK_READ) ? `MBS_HDR_LEN + {rd_cnt, 1'b0}
             : (kind == RK_EXC) ? `MBS_HDR_LEN : `MBS_ECHO_LEN;
        tx_free = !tx_valid || tx_ready;
        tx_load = tx_free && (user_raw_mode
                ? (raw_tx_valid && raw_tx_ready)
                : (state == ST_TX && tx_k < plen + 6'h02));
        if (user_raw_mode) begin
            tx_byte = raw_tx_data;
        end else if (tx_k == plen) begin
            tx_byte = crc_tx[7:0];
        end else if (tx_k == plen + 6'h01) begin
            tx_byte = crc_tx[15:8];
        end else if (kind == RK_ECHO) begin
            tx_byte = req_buf[tx_k];
        end else if (tx_k == 6'h00) begin
            tx_byte = node_addr;
        end else if (tx_k == 6'h01) begin
            tx_byte = (kind == RK_EXC) ? (req_buf[1] | `MBS_EXC_FLAG)
                                       : req_buf[1];
        end else if (tx_k == 6'h02) begin
            tx_byte = (kind == RK_EXC) ? `MBS_EXC_ADDR
                                       : {2'b00, rd_cnt, 1'b0};
        end else begin
            tx_byte = rd_buf[tx_k - `MBS_HDR_LEN];
        end
        next_tx_valid = tx_load || (tx_valid && !tx_ready);
    end

    // Transmit holding register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_valid     <= 1'b0;
            tx_data      <= 8'h00;
            raw_tx_ready <= 1'b0;
        end else begin
            tx_valid     <= next_tx_valid;
            raw_tx_ready <= user_raw_mode && !next_tx_valid;
            if (tx_load) begin
                tx_data <= tx_byte;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_raw_idle: assert property (user_raw_mode |=> state == ST_IDLE)
        else $error("Protocol active in raw mode");
    a_crc_drop: assert property (state == ST_CHECK && crc_rx != 16'h0000
        |=> state == ST_IDLE)
        else $error("Bad CRC frame not dropped");
    a_gap_close: assert property ($rose(state == ST_CHECK)
        |-> $past(gap))
        else $error("Frame closed without idle gap");
    a_bcast_quiet: assert property ($rose(state == ST_TX) |-> !bcast)
        else $error("Reply sent to broadcast");
    a_write_first: assert property ($rose(state == ST_TX) && kind == RK_ECHO
        |-> reg_wr)
        else $error("Echo before register write");
    a_limit_drop: assert property (state == ST_CHECK &&
        req_buf[1] == `MBS_FC_WRITEN && c1 > `MBS_MAX_REGS
        |=> state == ST_IDLE)
        else $error("Over-limit preset not dropped");
    a_read_exc: assert property (state == ST_CHECK && hit &&
        crc_rx == 16'h0000 && req_buf[1] == `MBS_FC_READ &&
        idx == `MBS_FIX_LEN && req_buf[0] != `MBS_BCAST &&
        c1 > `MBS_MAX_REGS |=> state == ST_TX && kind == RK_EXC)
        else $error("Over-limit read without exception");
    a_first_addr: assert property (state == ST_TX && tx_k == 6'h01 &&
        tx_valid |-> tx_data == node_addr)
        else $error("Reply not opened by node address");
    a_crc_low: assert property (state == ST_TX && tx_load &&
        tx_k == plen |=> tx_data == $past(crc_tx[7:0]))
        else $error("CRC low byte not first");
    a_code_kept: assert property (state == ST_TX && kind != RK_EXC |->
        req_buf[1] inside {`MBS_FC_READ, `MBS_FC_WRITE1,
        `MBS_FC_WRITEN, `MBS_FC_RDWR})
        else $error("Reply to unsupported code");

    c_read: cover property ($rose(state == ST_TX) && kind == RK_READ);
    c_echo: cover property ($rose(state == ST_TX) && kind == RK_ECHO);
    c_exc: cover property ($rose(state == ST_TX) && kind == RK_EXC);
    c_raw: cover property (user_raw_mode && tx_load);
endmodule

// file: hdl/mbs_params.svh
// Constants of the serial register-access slave
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH
`define MBS_FC_READ      8'h03
`define MBS_FC_WRITE1    8'h06
`define MBS_FC_WRITEN    8'h10
`define MBS_FC_RDWR      8'h17
`define MBS_EXC_FLAG     8'h80
`define MBS_EXC_ADDR     8'h02
`define MBS_BCAST        8'h00
`define MBS_MAX_NODE     8'hf7
`define MBS_MAX_REGS     16'h0014
`define MBS_POS_ADDR     6'h02
`define MBS_POS_CNT      6'h04
`define MBS_POS_WADDR    6'h06
`define MBS_POS_WCNT     6'h08
`define MBS_POS_BC_N     6'h06
`define MBS_POS_BC_RW    6'h0a
`define MBS_POS_DATA_1   6'h04
`define MBS_POS_DATA_N   6'h07
`define MBS_POS_DATA_RW  6'h0b
`define MBS_FIX_LEN      7'h08
`define MBS_HDR_N_LEN    16'h0009
`define MBS_HDR_RW_LEN   16'h000d
`define MBS_ECHO_LEN     6'h06
`define MBS_HDR_LEN      6'h03
`define MBS_CRC_INIT     16'hffff
`define MBS_CRC_POLY     16'ha001
`define MBS_CLK_HZ       64'd40000000
`define MBS_BAUD         64'd19200
`define MBS_CHAR_BITS    64'd11
`define MBS_GAP_HALVES   64'd7
`define MBS_GAP_CYCLES   ((`MBS_CLK_HZ * `MBS_CHAR_BITS * `MBS_GAP_HALVES \
    + 64'd2 * `MBS_BAUD - 64'd1) / (64'd2 * `MBS_BAUD))
`endif

// file: hdl/mbs_pkg.sv
// Types of the serial register-access slave
package mbs_pkg;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_CHECK  = 6'b000010,
        ST_WR     = 6'b000100,
        ST_RD_REQ = 6'b001000,
        ST_RD_CAP = 6'b010000,
        ST_TX     = 6'b100000
    } mbs_state_t;
    typedef enum logic [1:0] {
        RK_ECHO = 2'b00,
        RK_READ = 2'b01,
        RK_EXC  = 2'b10
    } mbs_kind_t;
endpackage

// file: hdl/mbs_crc16.sv
// Running reflected CRC-16 over a byte stream
`timescale 1ns/100ps
`include "mbs_params.svh"
module mbs_crc16 (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    logic [15:0] next_crc;   // Value after one byte

    // Eight shift steps of the reflected polynomial
    always_comb begin
        next_crc = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (next_crc[0]) begin
                next_crc = (next_crc >> 1) ^ `MBS_CRC_POLY;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    // Accumulator, preset on clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crc <= `MBS_CRC_INIT;
        end else if (clear) begin
            crc <= `MBS_CRC_INIT;
        end else if (en) begin
            crc <= next_crc;
        end
    end
endmodule

// file: hdl/mbs_gap_timer.sv
// Idle-gap detector closing a received frame
`timescale 1ns/100ps
module mbs_gap_timer #(
    parameter int GAP_CYCLES = 80209
)(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic kick,
    output logic      gap
);
    localparam int CW = $clog2(GAP_CYCLES + 1);
    logic [CW-1:0] count;   // Idle cycles since last byte
    logic          armed;   // A byte came since last gap

    // Count idle time, pulse once when the gap is reached
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            armed <= 1'b0;
            gap   <= 1'b0;
        end else begin
            gap <= 1'b0;
            if (kick) begin
                count <= '0;
                armed <= 1'b1;
            end else if (armed) begin
                if (count == CW'(GAP_CYCLES - 1)) begin
                    armed <= 1'b0;
                    gap   <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

// file: tb/mbs_store_model.sv
// Register store model answering the handler's read strobes
`timescale 1ns/100ps
module mbs_store_model (
    input  wire logic        reg_rd,
    input  wire logic [13:0] reg_addr,
    output logic      [31:0] reg_rdata
);
    // Upper half fixed, lower half is the index, so words are traceable
    // Data only while the read strobe stands, so a lost strobe shows
    assign reg_rdata = reg_rd ? {16'ha500, 2'b00, reg_addr}
                              : 32'h00000000;
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the frame interpreter, bench acts as master
`timescale 1ns/100ps
`include "mbs_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import mbs_pkg::*;
    localparam int         GAP  = 20;
    localparam logic [7:0] NODE = 8'h11;
    logic clk_sys = 0, nrst = 0, raw_mode = 0, rx_valid = 0, tx_ready = 0;
    logic raw_tx_valid = 0, tx_valid, raw_rx_valid, raw_tx_ready;
    logic [7:0]  rx_data = 0, raw_tx_data = 8'h5a, tx_data, raw_rx_data;
    logic        reg_wr, reg_rd, reg_wide;
    logic [13:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0]  exp_tx[$], fr[$], rp[$];
    logic [46:0] exp_wr[$], ew;
    logic [8:0]  eb;
    int          bad_count = 0, n_compared = 0;

    mbs_handler #(.GAP_CYCLES(GAP)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .node_addr(NODE), .user_raw_mode(raw_mode), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .raw_rx_valid(raw_rx_valid),
        .raw_rx_data(raw_rx_data), .raw_tx_valid(raw_tx_valid),
        .raw_tx_data(raw_tx_data), .raw_tx_ready(raw_tx_ready),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wide(reg_wide), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    mbs_store_model store_u (.reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata));

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    // Random transmit stalls from the UART side
    always @(negedge clk_sys) tx_ready <= ($urandom % 4) != 0;

    // Monitor: each byte or write taken off the oldest note
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) begin
            eb = exp_tx.size() ? {1'b0, exp_tx.pop_front()} : 9'h100;
            `CHK({1'b0, tx_data}, eb)
        end
        if (reg_wr) begin
            ew = exp_wr.size() ? exp_wr.pop_front() : '1;
            `CHK({reg_wide, reg_addr, reg_wdata}, ew)
        end
    end

    // Reflected CRC-16, low byte sent first
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c = `MBS_CRC_INIT;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `MBS_CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Send frame with CRC, optionally corrupted, one pulse per byte
    task automatic send(input bit bad);
        logic [15:0] c;
        c = crc(fr);
        fr.push_back(c[7:0] ^ {7'h0, bad});
        fr.push_back(c[15:8]);
        foreach (fr[i]) begin
            @(negedge clk_sys);
            rx_valid = 1;
            rx_data  = fr[i];
            @(negedge clk_sys);
            rx_valid = 0;
        end
        fr.delete();
    endtask

    // Note expected reply with its CRC
    task automatic resp();
        logic [15:0] c;
        c = crc(rp);
        rp.push_back(c[7:0]);
        rp.push_back(c[15:8]);
        foreach (rp[i]) exp_tx.push_back(rp[i]);
        rp.delete();
    endtask

    // Bounded wait for all notes, then an idle gap
    task automatic settle();
        for (int k = 0; k < 4000 && (exp_tx.size() || exp_wr.size()); k++)
            @(negedge clk_sys);
        if (exp_tx.size() || exp_wr.size()) begin
            `CHK(1'b1, 1'b0)
            end_sim();
        end
        repeat (GAP + 12) @(negedge clk_sys);
    endtask

    // Read reply: narrow words or wide pairs, high byte first
    task automatic rdexp(input logic [7:0] fc, input logic [15:0] st, int n);
        logic [15:0] v;
        rp = '{NODE, fc, 8'(2 * n)};
        for (int w = 0; w < n; w++) begin
            v = {2'b00, st[13:0] + 14'(st[14] ? w / 2 : w)};
            if (st[14] && w % 2 == 0) v = 16'ha500;
            rp.push_back(v[15:8]);
            rp.push_back(v[7:0]);
        end
        resp();
    endtask

    // Preset multiple: narrow words, or wide items as word pairs
    task automatic wmul(input int n, input bit wide);
        logic [15:0] d, hi;
        fr = '{NODE, `MBS_FC_WRITEN, {1'b0, wide, 6'h00}, 8'h30, 8'h00,
               8'(n), 8'(2 * n)};
        rp = fr[0:5];
        for (int i = 0; i < n; i++) begin
            hi = d;
            d  = 16'($urandom);
            fr.push_back(d[15:8]);
            fr.push_back(d[7:0]);
            if (n <= 20 && !wide)
                exp_wr.push_back({1'b0, 14'h30 + 14'(i), 16'h0, d});
            else if (n <= 20 && i % 2 == 1)
                exp_wr.push_back({1'b1, 14'h30 + 14'(i / 2), hi, d});
        end
        send(0);
        if (n <= 20) resp();
        rp.delete();
        settle();
    endtask

    initial begin
        void'($urandom(32'h350859f4));
        repeat (6) @(negedge clk_sys);
        nrst = 1;
        repeat (2) @(negedge clk_sys);
        // Single preset echoed after write
        fr = '{NODE, `MBS_FC_WRITE1, 8'h00, 8'h05, 8'hbe, 8'hef};
        rp = fr;
        exp_wr.push_back({1'b0, 14'h0005, 32'h0000beef});
        send(0);
        resp();
        settle();
        // Reads: 1, limit 20, wide 4, over limit, reserved width
        for (int t = 0; t < 5; t++) begin
            automatic logic [15:0] st = 16'($urandom % 200);
            automatic int n = t == 0 ? 1 : t == 1 ? 20 : t == 2 ? 4 : 21;
            st[14] = t == 2;
            st[15] = t == 4;
            if (t == 4) n = 1;
            fr = '{NODE, `MBS_FC_READ, st[15:8], st[7:0], 8'h00, 8'(n)};
            send(0);
            if (n > 20 || st[15]) begin
                rp = '{NODE, 8'h83, 8'h02};
                resp();
            end else rdexp(`MBS_FC_READ, st, n);
            settle();
        end
        wmul(2, 1'b0);
        wmul(4, 1'b1);
        wmul(21, 1'b0);
        // Combined write one then read one
        fr = '{NODE, `MBS_FC_RDWR, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h50,
               8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
        exp_wr.push_back({1'b0, 14'h0050, 32'h00001234});
        send(0);
        rdexp(`MBS_FC_RDWR, 16'h0040, 1);
        settle();
        // Broadcast write runs silently
        fr = '{8'h00, `MBS_FC_WRITE1, 8'h00, 8'h07, 8'h00, 8'h09};
        exp_wr.push_back({1'b0, 14'h0007, 32'h00000009});
        send(0);
        settle();
        // Bad CRC, foreign node, unknown code: all silent
        fr = '{NODE, `MBS_FC_WRITE1, 8'h00, 8'h01, 8'h00, 8'h01};
        send(1);
        settle();
        fr = '{8'h12, `MBS_FC_READ, 8'h00, 8'h01, 8'h00, 8'h01};
        send(0);
        settle();
        fr = '{NODE, 8'h04, 8'h00, 8'h01, 8'h00, 8'h01};
        send(0);
        settle();
        // Raw mode mirrors received byte and sends user byte
        raw_mode = 1;
        repeat (3) @(negedge clk_sys);
        rx_valid = 1;
        rx_data  = 8'hc3;
        @(negedge clk_sys);
        rx_valid = 0;
        `CHK({raw_rx_valid, raw_rx_data}, 9'h1c3)
        exp_tx.push_back(8'h5a);
        raw_tx_valid = 1;
        for (int k = 0; k < 50 && !raw_tx_ready; k++) @(negedge clk_sys);
        `CHK(raw_tx_ready, 1'b1)
        @(negedge clk_sys);
        raw_tx_valid = 0;
        settle();
        end_sim();
    end
endmodule
